// ==== common/timer_consts.vh ====
// Register offsets, field positions, reset values, mode codes and the count wrap point for the event timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// Register indices of the counter registers; their byte address is four times the index
`define IDX_COUNT      8'h0d
`define IDX_CONTROL    8'h0e
// Byte addresses of the registers, one aligned word each
`define OFS_COUNT      12'h034
`define OFS_CONTROL    12'h038
`define OFS_IRQ_STATUS 12'h040
`define OFS_IRQ_MASK   12'h044
`define OFS_SYSCTRL    12'h048
// Control register fields
`define CTL_PSC_LSB    0
`define CTL_PSC_MSB    2
`define CTL_EDGE       3
`define CTL_RUN        4
`define CTL_MODE_LSB   6
`define CTL_MODE_MSB   7
`define CTL_RESET      8'h08
`define CTL_WMASK      8'hdf
// Mode codes
`define MODE_UNUSED    2'b00
`define MODE_EVENT     2'b01
`define MODE_TIMER     2'b10
`define MODE_PULSE     2'b11
// Status / mask bit positions
`define IRQ_OVF        0
`define IRQ_WAKE       1
// System control register bits
`define SYS_HALT       0
`define SYS_WARM       1
// Count wrap point
`define COUNT_TOP      8'hff
`endif

// ==== core/edge_detect.v ====
// Edge detector for the external count input, taken as synchronous to the clock
`timescale 1ns/1ps
module edge_detect (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Input pin level
    input wire pin,
    // Edge pulses and delayed level
    output wire rise,
    output wire fall,
    output reg level_reg
);
    // Previous level holder
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= pin;
        end
    end
    assign rise = pin & ~level_reg;
    assign fall = ~pin & level_reg;
endmodule // edge_detect

// ==== core/event_timer.v ====
// Eight-bit timer/event counter with preload, control, interrupt and tone output behind AHB-Lite
// Contract
// - Eight-bit up-counter, pin or prescaled clock
// - Tone toggles each overflow, halving overflow rate
// - Count address: write preload, read live count
// - Two mode bits choose event, timer, pulse
// - Overflow reloads preload and sets flag together
// - Pulse mode: start on edge, stop, clear run
// - One measurement held until run set again
// - Pulse count starts only on an edge
// - Pulse mode overflow also reloads and flags
// - Counting only while run bit is one
// - Hardware clears run only after pulse measurement
// - Overflow is a wake-up source
// - Zero interrupt enable blocks overflow interrupts
// - Chip reset loads control 08h, counter stopped
// - Warm reset keeps counter, preload, control
// - Mode codes 01 event, 10 timer, 11 pulse
// - Prescale field divides clock by 2^field
// - Event edge select 1 falling, 0 rising
// - Write while stopped also loads counter
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "timer_consts.vh"
module event_timer #(
    parameter PSC_WIDTH = 7
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // External event and pulse input
    input wire count_value_and_event_input,
    // Tone, interrupt and wake-up outputs
    output reg tone_output,
    output reg irq,
    output reg wakeup
);
    reg [7:0] count_reg; // Live counter
    reg [7:0] preload_reg; // Preload value
    reg [7:0] control_reg; // Control register
    reg [1:0] status_reg; // Sticky event bits
    reg [1:0] mask_reg; // Interrupt mask, bit 0 is the overflow interrupt enable
    reg [1:0] sysctrl_reg; // Halt and warm-reset controls
    reg pulse_active_reg; // Pulse measurement in progress
    reg wr_pend_reg; // Write data phase pending
    reg [11:0] wr_addr_reg; // Latched write address
    reg [7:0] count_next; // Next counter value
    reg overflow; // Overflow this cycle
    reg count_en; // Counter advances this cycle
    wire psc_tick; // Prescaled clock enable
    wire pin_rise; // Rising pin edge
    wire pin_fall; // Falling pin edge
    wire pin_level; // Delayed pin level
    wire [1:0] mode; // Operating mode
    wire run; // Run bit
    wire edge_sel; // Edge select bit
    wire warm_hold; // Warm reset in effect
    wire addr_ok; // Address phase valid
    wire wr_data; // Write data phase now
    wire wr_count; // Write to count address
    wire wr_control; // Write to control address
    wire wr_status; // Write to status address
    wire wr_mask; // Write to mask address
    wire wr_sys; // Write to system control address
    wire pulse_start; // Activating edge seen
    wire pulse_stop; // Return edge seen
    wire [1:0] status_set; // Hardware set terms

    // Register decode used for reads and writes
    function [2:0] decode;
        input [11:0] a;
        begin
            case (a)
                `OFS_COUNT: decode = 3'h1;
                `OFS_CONTROL: decode = 3'h2;
                `OFS_IRQ_STATUS: decode = 3'h3;
                `OFS_IRQ_MASK: decode = 3'h4;
                `OFS_SYSCTRL: decode = 3'h5;
                default: decode = 3'h0;
            endcase
        end
    endfunction

    assign mode = control_reg[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign run = control_reg[`CTL_RUN];
    assign edge_sel = control_reg[`CTL_EDGE];
    assign warm_hold = sysctrl_reg[`SYS_WARM];
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_data = wr_pend_reg;
    assign wr_count = wr_data & (decode(wr_addr_reg) == 3'h1);
    assign wr_control = wr_data & (decode(wr_addr_reg) == 3'h2);
    assign wr_status = wr_data & (decode(wr_addr_reg) == 3'h3);
    assign wr_mask = wr_data & (decode(wr_addr_reg) == 3'h4);
    assign wr_sys = wr_data & (decode(wr_addr_reg) == 3'h5);
    // Activating edge: rising when edge select is one, falling otherwise
    assign pulse_start = edge_sel ? pin_rise : pin_fall;
    assign pulse_stop = edge_sel ? pin_fall : pin_rise;

    // Prescaler for the internal counter clock
    prescaler #(
        .WIDTH(PSC_WIDTH)
    ) u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(~run),
        .select(control_reg[`CTL_PSC_MSB:`CTL_PSC_LSB]),
        .tick(psc_tick)
    );

    // Edge detector for the event pin
    edge_detect u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(count_value_and_event_input),
        .rise(pin_rise),
        .fall(pin_fall),
        .level_reg(pin_level)
    );

    // Counting enable by mode
    always @* begin
        count_en = 1'b0;
        if (run && !warm_hold) begin
            case (mode)
                `MODE_EVENT: count_en = edge_sel ? pin_fall : pin_rise;
                `MODE_TIMER: count_en = psc_tick;
                `MODE_PULSE: count_en = pulse_active_reg & psc_tick;
                default: count_en = 1'b0;
            endcase
        end
        overflow = count_en & (count_reg == `COUNT_TOP);
        if (overflow) begin
            count_next = preload_reg;
        end else if (count_en) begin
            count_next = count_reg + 8'h01;
        end else begin
            count_next = count_reg;
        end
    end

    // Counter and preload; a write while stopped also loads the counter
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 8'h00;
            preload_reg <= 8'h00;
        end else begin
            if (wr_count) begin
                preload_reg <= hwdata[7:0];
            end
            if (wr_count && !run) begin
                count_reg <= hwdata[7:0];
            end else begin
                count_reg <= count_next;
            end
        end
    end

    // Control register and pulse measurement state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= `CTL_RESET;
            pulse_active_reg <= 1'b0;
        end else if (wr_control) begin
            control_reg <= hwdata[7:0] & `CTL_WMASK;
            pulse_active_reg <= 1'b0; // Setting run re-arms one measurement
        end else if (mode == `MODE_PULSE && run && !warm_hold) begin
            if (!pulse_active_reg && pulse_start) begin
                pulse_active_reg <= 1'b1;
            end else if (pulse_active_reg && pulse_stop) begin
                pulse_active_reg <= 1'b0;
                control_reg[`CTL_RUN] <= 1'b0; // Result held, later edges ignored
            end
        end else begin
            pulse_active_reg <= 1'b0;
        end
    end

    // Sticky status: set wins over write-one-to-clear
    // Wake bit only for an overflow seen while halted
    assign status_set = {overflow & sysctrl_reg[`SYS_HALT], overflow};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= 2'b00;
            mask_reg <= 2'b00;
            sysctrl_reg <= 2'b00;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? hwdata[1:0] : 2'b00)) | status_set;
            if (wr_mask) begin
                mask_reg <= hwdata[1:0];
            end
            if (wr_sys) begin
                sysctrl_reg <= hwdata[1:0];
            end else if (wakeup) begin
                sysctrl_reg[`SYS_HALT] <= 1'b0; // Overflow leaves the halted state
            end
        end
    end

    // Outputs: tone, interrupt and wake-up
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tone_output <= 1'b0;
            irq <= 1'b0;
            wakeup <= 1'b0;
        end else begin
            if (overflow) begin
                tone_output <= ~tone_output;
            end
            irq <= |(status_next_masked(status_reg, status_set, wr_status, hwdata[1:0]) & mask_reg);
            wakeup <= overflow & sysctrl_reg[`SYS_HALT];
        end
    end

    // Status value after this cycle's update
    function [1:0] status_next_masked;
        input [1:0] cur;
        input [1:0] set;
        input clr_en;
        input [1:0] clr;
        begin
            status_next_masked = (cur & ~(clr_en ? clr : 2'b00)) | set;
        end
    endfunction

    // AHB-Lite slave: zero wait states, OKAY always, reads registered
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok) begin
                wr_addr_reg <= haddr;
            end
            if (addr_ok && !hwrite) begin
                case (decode(haddr))
                    3'h1: hrdata <= {24'h000000, count_next};
                    3'h2: hrdata <= {24'h000000, control_reg & `CTL_WMASK};
                    3'h3: hrdata <= {30'h00000000, status_reg | status_set};
                    3'h4: hrdata <= {30'h00000000, mask_reg};
                    3'h5: hrdata <= {30'h00000000, sysctrl_reg};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // event_timer

// ==== core/prescaler.v ====
// Prescaler producing a one-cycle enable at the system clock divided by two to the select power
`timescale 1ns/1ps
module prescaler #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Control
    input wire clear,
    input wire [2:0] select,
    // Enable pulse
    output reg tick
);
    reg [WIDTH-1:0] div_reg; // Free-running divider
    wire [WIDTH-1:0] lowmask; // Bits that must be all ones for a tick
    assign lowmask = ~({WIDTH{1'b1}} << select);

    // Divider counts system clocks; tick when the selected low bits wrap
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (clear) begin
            div_reg <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else begin
            div_reg <= div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            tick <= ((div_reg & lowmask) == lowmask);
        end
    end
endmodule // prescaler

// ==== sim/event_timer_props.sv ====
// Port-level checker for the event timer
`timescale 1ns/1ps
`include "timer_consts.vh"
module event_timer_props (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Outputs
    input wire tone_output,
    input wire irq,
    input wire wakeup
);
    reg ap_v, ap_w; // Data phase pending, its direction
    reg [11:0] ap_a; // Its address
    reg [7:0] ctl_sh, msk_sh; // Shadows of control and mask
    wire rd = ap_v && !ap_w; // Read data phase
    // Follow bus writes to keep shadows
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_v <= 1'b0;
            ap_w <= 1'b0;
            ap_a <= 12'h000;
            ctl_sh <= `CTL_RESET;
            msk_sh <= 8'h00;
        end else begin
            ap_v <= hsel & hready & htrans[1];
            ap_w <= hwrite;
            ap_a <= haddr;
            if (ap_v && ap_w && ap_a == `OFS_CONTROL) ctl_sh <= hwdata[7:0] & `CTL_WMASK;
            if (ap_v && ap_w && ap_a == `OFS_IRQ_MASK) msk_sh <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_unmap; rd && ap_a > `OFS_SYSCTRL |-> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctl; rd && ap_a == `OFS_CONTROL |-> (hrdata & 32'hffffffef) == {24'h0, ctl_sh & 8'hef}; endproperty
    a_ctl: assert property (p_ctl) else $error("control readback wrong");
    property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_mask; msk_sh[1:0] == 2'h0 && $past(msk_sh[1:0]) == 2'h0 |-> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq raised");
    property p_wake; wakeup |=> !wakeup; endproperty
    a_wake: assert property (p_wake) else $error("wakeup too long");
    property p_tone; $changed(tone_output) |-> $past(ctl_sh[4]) || $past(ctl_sh[4], 2); endproperty
    a_tone: assert property (p_tone) else $error("tone moved while stopped");
    c_wake: cover property (wakeup);
    c_irq: cover property ($rose(irq));
    c_tone: cover property ($changed(tone_output));
endmodule // event_timer_props
bind event_timer event_timer_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tone_output(tone_output), .irq(irq), .wakeup(wakeup));

// ==== sim/pin_model.sv ====
// Partner model: drives the external count pin with single high pulses
`timescale 1ns/1ps
module pin_model (
    // Clock and pulse request
    input wire hclk,
    input wire fire,
    input wire [7:0] len,
    // Pin level, low between pulses
    output wire pin
);
    logic [7:0] n = 8'h00; // High cycles left
    // Load on request, then count down to release
    always @(posedge hclk) begin
        n <= fire ? len : n - {7'h00, n != 8'h00};
    end
    assign pin = (n != 8'h00);
endmodule // pin_model

// ==== sim/timer_event_counter_8bit_test.sv ====
// Self-checking bench for the eight-bit event timer
`timescale 1ns/1ps
`include "timer_consts.vh"
module timer_event_counter_8bit_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, q, q1;
    logic [7:0] len = 8'h01;
    wire [31:0] hrdata;
    wire hreadyout, hresp, pin, tone_output, irq, wakeup;
    int n_fail = 0, n_checks = 0;
    event_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_value_and_event_input(pin), .tone_output(tone_output), .irq(irq), .wakeup(wakeup));
    pin_model u_pin (.hclk(hclk), .fire(fire), .len(len), .pin(pin));
    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    // One single transfer, entered just after a clock edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(s, q, e);
    endtask
    task automatic pulse(input logic [7:0] n, input int c);
        len <= n;
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        repeat (c) @(posedge hclk);
    endtask
    // Measures cycles between two tone changes
    task automatic per(input int e);
        logic t;
        int n;
        n = 0;
        t = tone_output;
        while (tone_output === t) @(posedge hclk);
        t = tone_output;
        while (tone_output === t) begin
            @(posedge hclk);
            n++;
        end
        chk("tone", n, e);
    endtask
    // Timer mode, prescale, reload, interrupt mask and clear
    task automatic t_timer;
        rc("ctl", `OFS_CONTROL, 32'h8);
        rc("unmap", 12'h020, 32'h0);
        xfer(1'b1, `OFS_COUNT, 32'hf0);
        rc("load", `OFS_COUNT, 32'hf0);
        for (int p = 0; p < 3; p++) begin
            xfer(1'b1, `OFS_CONTROL, 32'h90 | p);
            per(16 << p);
        end
        xfer(1'b1, `OFS_CONTROL, 32'h90);
        xfer(1'b1, `OFS_COUNT, 32'he0);
        per(32);
        xfer(1'b1, `OFS_CONTROL, 32'h80);
        rc("flag", `OFS_IRQ_STATUS, 32'h1);
        chk("nomask", irq, 1'b0);
        xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq", irq, 1'b1);
        xfer(1'b1, `OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk("clr", irq, 1'b0);
    endtask
    // Overflow while halted wakes the block
    task automatic t_wake;
        xfer(1'b1, `OFS_IRQ_MASK, 32'h2);
        xfer(1'b1, `OFS_COUNT, 32'hfc);
        xfer(1'b1, `OFS_SYSCTRL, 32'h1);
        xfer(1'b1, `OFS_CONTROL, 32'h90);
        for (int i = 0; i < 20 && wakeup !== 1'b1; i++) @(posedge hclk);
        chk("wake", wakeup, 1'b1);
        rc("halt", `OFS_SYSCTRL, 32'h0);
        chk("wirq", irq, 1'b1);
        // Warm hold freezes the running counter
        xfer(1'b1, `OFS_SYSCTRL, 32'h2);
        xfer(1'b0, `OFS_COUNT, 32'h0);
        q1 = q;
        repeat (10) @(posedge hclk);
        rc("warm", `OFS_COUNT, q1);
        xfer(1'b1, `OFS_SYSCTRL, 32'h0);
    endtask
    // Event counting on each edge choice
    task automatic t_event;
        for (int e = 0; e < 2; e++) begin
            xfer(1'b1, `OFS_CONTROL, 32'h0);
            xfer(1'b1, `OFS_COUNT, 32'h0);
            xfer(1'b1, `OFS_CONTROL, 32'h50 | (e << 3));
            pulse(8'h14, 3);
            rc("edge", `OFS_COUNT, 32'h1 - e);
            repeat (30) @(posedge hclk);
            rc("event", `OFS_COUNT, 32'h1);
        end
    endtask
    // One pulse-width measurement, held until re-armed
    task automatic t_pulse;
        xfer(1'b1, `OFS_CONTROL, 32'h0);
        xfer(1'b1, `OFS_COUNT, 32'h0);
        xfer(1'b1, `OFS_CONTROL, 32'hd8);
        pulse(8'h0a, 20);
        xfer(1'b0, `OFS_COUNT, 32'h0);
        q1 = q;
        chk("width", q1 > 8 && q1 < 12, 1'b1);
        rc("done", `OFS_CONTROL, 32'hc8);
        pulse(8'h05, 20);
        rc("once", `OFS_COUNT, q1);
        pulse(8'h28, 5);
        xfer(1'b1, `OFS_CONTROL, 32'hd8);
        repeat (50) @(posedge hclk);
        rc("level", `OFS_CONTROL, 32'hd8);
        pulse(8'h05, 20);
        rc("rearm", `OFS_CONTROL, 32'hc8);
    endtask
    // Clock of 100 ns period
    initial begin
        forever #50 hclk = ~hclk;
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        end_of_test;
    end
    // Reset, then scenarios
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_timer;
        t_wake;
        t_event;
        t_pulse;
        end_of_test;
    end
endmodule // timer_event_counter_8bit_test
